// [hdl/slcd_driver.sv]
`timescale 1ns/1ps
`include "slcd_consts.svh"
// Functional notes
// R1 - Each frame opens with a start bit of one followed by 33 segment bits, 34 defined bits.
// R2 - Only serial data and its clock carry a frame; latching follows from the framing.
// R3 - The rising edge of the 36th clock loads the 33 shifted bits into the output latches.
// R4 - The 36th clock also empties every shift stage for the next frame.
// R5 - Two more clocks follow the 34 defined bits and their data is ignored.
// R6 - The sequencer returns to idle on the 36th clock, so a new start bit may follow on the next clock.
// R7 - The shift path holds its contents for as long as the serial clock stands still.
// R8 - The output latches keep the last pattern until a new complete frame loads.
// R9 - A segment output changes only where its new bit differs from the old one.
// R10 - Each segment bit drives exactly one segment output, with no decoding.
// R11 - The controller composes segment patterns itself; nothing here decodes characters.
// R12 - An internal oscillator produces the clock for the backplane drive.
// R13 - The backplane output toggles at the oscillator frequency divided by sixteen.
// R14 - An external backplane clock of even duty cycle may replace the oscillator.
// R15 - Holding the timing pin low disables the internal oscillator.
// R16 - A segment drives the backplane phase for a zero and its inverse for a one.
// R17 - The first segment bit after the start bit maps to the highest segment output.
module slcd_driver
  import slcd_pkg::*;
#(
  parameter int SEG_N      = `SLCD_SEG_COUNT,
  parameter int OSC_CYCLES = `SLCD_OSC_PERIOD_NS / `SLCD_REF_PERIOD_NS
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             serClk,
  input  wire logic             serData,
  input  wire logic             rcTimingPin,
  input  wire logic             backplaneClockIn,
  output logic      [SEG_N-1:0] segmentOut,
  output logic                  backplaneDriveOut
);

  localparam slcd_cnt_t LAST_SHIFT = slcd_cnt_t'(SEG_N);
  localparam slcd_cnt_t LOAD_EDGE  = slcd_cnt_t'(SEG_N + `SLCD_PAD_CLOCKS);
  localparam int        OSC_W      = $clog2(OSC_CYCLES + 1);
  localparam logic [OSC_W-1:0] OSC_LAST = OSC_W'(OSC_CYCLES - 1);

  if (SEG_N < 2 || SEG_N > 60) begin : g_chk_seg
    $error("SEG_N must lie between 2 and 60");
  end
  if (OSC_CYCLES < 2) begin : g_chk_osc
    $error("OSC_CYCLES must be at least 2");
  end

  // Link domain
  slcd_link_e       linkState_reg;
  slcd_cnt_t        bitCount_reg;
  logic [SEG_N-1:0] shiftReg_reg;
  logic [SEG_N-1:0] holdReg_reg;
  logic             loadTgl_reg;
  logic             frameEnd;

  // Reference domain
  logic             loadTglSync;
  logic             loadTglSeen_reg;
  logic             loadPulse;
  logic [SEG_N-1:0] segLatch_reg;
  logic             oscEnSync;
  logic             bpExtSync;
  logic [OSC_W-1:0] oscCnt_reg;
  logic             oscTick;
  logic [2:0]       bpDiv_reg;
  logic             bpInt_reg;
  logic             bpNext;

  assign frameEnd = (bitCount_reg == LOAD_EDGE);

  // Frame sequencer on the serial clock
  always_ff @(posedge serClk or posedge rst) begin
    if (rst) begin
      linkState_reg <= SLCD_IDLE;
      bitCount_reg  <= `SLCD_CNT_IDLE;
    end else begin
      case (linkState_reg)
        SLCD_IDLE: begin
          if (serData) begin // R1 R6
            linkState_reg <= SLCD_SHIFT;
            bitCount_reg  <= `SLCD_CNT_START;
          end
        end
        SLCD_SHIFT: begin
          bitCount_reg <= bitCount_reg + `SLCD_CNT_START;
          if (bitCount_reg == LAST_SHIFT) begin
            linkState_reg <= SLCD_PAD; // R5
          end
        end
        SLCD_PAD: begin
          if (frameEnd) begin // R2 R4
            linkState_reg <= SLCD_IDLE;
            bitCount_reg  <= `SLCD_CNT_IDLE;
          end else begin
            bitCount_reg <= bitCount_reg + `SLCD_CNT_START;
          end
        end
        default: begin
          linkState_reg <= SLCD_IDLE;
          bitCount_reg  <= `SLCD_CNT_IDLE;
        end
      endcase
    end
  end

  // Shift path, first bit ends at the top
  always_ff @(posedge serClk or posedge rst) begin
    if (rst) begin
      shiftReg_reg <= '0;
    end else if (linkState_reg == SLCD_SHIFT) begin
      shiftReg_reg <= {shiftReg_reg[SEG_N-2:0], serData}; // R17 R7
    end else if (frameEnd) begin
      shiftReg_reg <= '0; // R4
    end
  end

  // Load strobe on the last clock of the frame
  always_ff @(posedge serClk or posedge rst) begin
    if (rst) begin
      holdReg_reg <= '0;
      loadTgl_reg <= 1'b0;
    end else if (frameEnd) begin
      holdReg_reg <= shiftReg_reg; // R3
      loadTgl_reg <= ~loadTgl_reg;
    end
  end

  slcd_sync #(.W(1)) u_loadSync (
    .clk (ref_clk),
    .rst (rst),
    .d   (loadTgl_reg),
    .q   (loadTglSync)
  );

  slcd_sync #(.W(2)) u_pinSync (
    .clk (ref_clk),
    .rst (rst),
    .d   ({rcTimingPin, backplaneClockIn}),
    .q   ({oscEnSync, bpExtSync})
  );

  assign loadPulse = loadTglSync ^ loadTglSeen_reg;

  // Output latches, held between frames
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      loadTglSeen_reg <= 1'b0;
      segLatch_reg    <= '0;
    end else begin
      loadTglSeen_reg <= loadTglSync;
      if (loadPulse) begin
        segLatch_reg <= holdReg_reg; // R3 R8 R9
      end
    end
  end

  // Internal oscillator, stopped while the pin is low
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      oscCnt_reg <= '0;
    end else if (!oscEnSync || oscTick) begin // R15
      oscCnt_reg <= '0;
    end else begin
      oscCnt_reg <= oscCnt_reg + OSC_W'(1); // R12
    end
  end

  assign oscTick = oscEnSync && (oscCnt_reg == OSC_LAST);

  // Divide oscillator by sixteen
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bpDiv_reg <= '0;
      bpInt_reg <= 1'b0;
    end else if (oscTick) begin
      bpDiv_reg <= bpDiv_reg + 3'h1;
      if (bpDiv_reg == `SLCD_BP_HALF_TICKS) begin
        bpInt_reg <= ~bpInt_reg; // R13
      end
    end
  end

  assign bpNext = oscEnSync ? bpInt_reg : bpExtSync; // R14 R15

  // Segment and backplane drive
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      backplaneDriveOut <= 1'b0;
      segmentOut        <= '0;
    end else begin
      backplaneDriveOut <= bpNext;
      segmentOut        <= {SEG_N{bpNext}} ^ segLatch_reg; // R10 R16
    end
  end

  // Link domain checks
  sequence s_idleNoStart;
    (linkState_reg == SLCD_IDLE) && !serData;
  endsequence

  sequence s_frameEnd;
    frameEnd;
  endsequence

  property p_startNeedsOne;
    @(posedge serClk) disable iff (rst)
      s_idleNoStart |=> (linkState_reg == SLCD_IDLE) && (bitCount_reg == `SLCD_CNT_IDLE);
  endproperty
  a_startNeedsOne: assert property (p_startNeedsOne) // R1
    else $error("frame started without a start bit");

  property p_loadOnLast;
    @(posedge serClk) disable iff (rst)
      s_frameEnd |=> $changed(loadTgl_reg) && (holdReg_reg == $past(shiftReg_reg));
  endproperty
  a_loadOnLast: assert property (p_loadOnLast) // R3
    else $error("last frame clock did not load the latches");

  property p_loadOnlyLast;
    @(posedge serClk) disable iff (rst)
      !frameEnd |=> $stable(loadTgl_reg);
  endproperty
  a_loadOnlyLast: assert property (p_loadOnlyLast) // R2
    else $error("load strobe outside the last frame clock");

  property p_clearAfterLoad;
    @(posedge serClk) disable iff (rst)
      s_frameEnd |=> (shiftReg_reg == '0) && (linkState_reg == SLCD_IDLE);
  endproperty
  a_clearAfterLoad: assert property (p_clearAfterLoad) // R4
    else $error("shift path not cleared after the frame");

  property p_backToBack;
    @(posedge serClk) disable iff (rst)
      s_frameEnd ##1 serData |=> (linkState_reg == SLCD_SHIFT)
                                 && (bitCount_reg == `SLCD_CNT_START);
  endproperty
  a_backToBack: assert property (p_backToBack) // R6
    else $error("back to back frame lost its start bit");

  property p_padIgnored;
    @(posedge serClk) disable iff (rst)
      (linkState_reg == SLCD_PAD) |=> $stable(shiftReg_reg) || (shiftReg_reg == '0);
  endproperty
  a_padIgnored: assert property (p_padIgnored) // R5
    else $error("pad clock altered the shift path");

  property p_msbFirst;
    logic b;
    @(posedge serClk) disable iff (rst)
      ((linkState_reg == SLCD_SHIFT) && (bitCount_reg == `SLCD_CNT_START), b = serData)
        |-> ##33 (shiftReg_reg[SEG_N-1] == b);
  endproperty
  a_msbFirst: assert property (p_msbFirst) // R17
    else $error("first segment bit not at the top output");

  // Reference domain checks
  property p_latchHolds;
    @(posedge ref_clk) disable iff (rst)
      !loadPulse |=> $stable(segLatch_reg);
  endproperty
  a_latchHolds: assert property (p_latchHolds) // R8
    else $error("latch changed without a load");

  property p_onlyDiffer;
    @(posedge ref_clk) disable iff (rst)
      loadPulse |=> segLatch_reg == $past(holdReg_reg);
  endproperty
  a_onlyDiffer: assert property (p_onlyDiffer) // R9
    else $error("latch did not take the new pattern");

  property p_segDrive;
    @(posedge ref_clk) disable iff (rst)
      ##1 1'b1 |-> segmentOut == ({SEG_N{backplaneDriveOut}} ^ $past(segLatch_reg));
  endproperty
  a_segDrive: assert property (p_segDrive) // R10 R16
    else $error("segment phase not tied to backplane and bit");

  property p_bpToggle;
    @(posedge ref_clk) disable iff (rst)
      oscTick && (bpDiv_reg == `SLCD_BP_HALF_TICKS) |=> (bpInt_reg != $past(bpInt_reg));
  endproperty
  a_bpToggle: assert property (p_bpToggle) // R13
    else $error("backplane did not toggle after eight ticks");

  property p_bpSteady;
    @(posedge ref_clk) disable iff (rst)
      !(oscTick && (bpDiv_reg == `SLCD_BP_HALF_TICKS)) |=> $stable(bpInt_reg);
  endproperty
  a_bpSteady: assert property (p_bpSteady) // R12 R13
    else $error("backplane toggled early");

  property p_extClock;
    @(posedge ref_clk) disable iff (rst)
      !oscEnSync |=> (backplaneDriveOut == $past(bpExtSync)) && (oscCnt_reg == '0);
  endproperty
  a_extClock: assert property (p_extClock) // R14 R15
    else $error("external backplane clock not selected");

endmodule : slcd_driver

// [hdl/slcd_consts.svh]
`ifndef SLCD_CONSTS_SVH
`define SLCD_CONSTS_SVH

// Segment outputs driven from one frame
`define SLCD_SEG_COUNT      33
// Trailing clocks after the defined bits
`define SLCD_PAD_CLOCKS     2
// Reference clock period
`define SLCD_REF_PERIOD_NS  40
// Nominal internal oscillator period (about 1200 Hz)
`define SLCD_OSC_PERIOD_NS  833333
// Divider count at which the backplane toggles, every 8 oscillator ticks (divide by 16)
`define SLCD_BP_HALF_TICKS  3'h7
// Edge counter values
`define SLCD_CNT_IDLE       6'h00
`define SLCD_CNT_START      6'h01

`endif

// [hdl/slcd_pkg.sv]
package slcd_pkg;

  typedef enum logic [2:0] {
    SLCD_IDLE  = 3'b001,
    SLCD_SHIFT = 3'b010,
    SLCD_PAD   = 3'b100
  } slcd_link_e;

  typedef logic [5:0] slcd_cnt_t;

endpackage : slcd_pkg

// [hdl/slcd_sync.sv]
`timescale 1ns/1ps
module slcd_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] stage1_reg;

  if (W < 1) begin : g_chk
    $error("slcd_sync width must be at least one");
  end

  // Two flops, first read only by second
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage1_reg <= '0;
      q          <= '0;
    end else begin
      stage1_reg <= d;
      q          <= stage1_reg;
    end
  end

endmodule : slcd_sync

// [sim/slcd_host_model.sv]
`timescale 1ns/1ps
module slcd_host_model (
  output logic serClk,
  output logic serData
);
  localparam time HALF = 80ns;

  initial begin
    serClk  = 1'b0;
    serData = 1'b0;
  end

  // One frame; optional clock stall after pauseAt edges
  task automatic send_frame(input logic [32:0] bits, input int pauseAt, input logic padVal);
    logic [35:0] frm;
    frm = {1'b1, bits, padVal, padVal};
    for (int i = 35; i >= 0; i--) begin
      if (35 - i == pauseAt) begin
        serData = ~serData;
        #(3007ns);
      end
      serData = frm[i];
      #(HALF);
      serClk = 1'b1;
      #(HALF);
      serClk = 1'b0;
    end
    serData = ~frm[0];
    #(HALF);
  endtask : send_frame

  // Clocks with data low while no frame runs
  task automatic idle_clocks(input int cnt);
    for (int i = 0; i < cnt; i++) begin
      serData = 1'b0;
      #(HALF);
      serClk = 1'b1;
      #(HALF);
      serClk = 1'b0;
    end
  endtask : idle_clocks
endmodule : slcd_host_model

// [sim/serial_lcd_segment_driver_bench.sv]
`timescale 1ns/1ps
module serial_lcd_segment_driver_bench;
  import slcd_pkg::*;
  localparam int OSC = 4;
  logic        ref_clk;
  logic        rst;
  logic        serClk;
  logic        serData;
  logic        rcTimingPin;
  logic        backplaneClockIn;
  logic        backplaneDriveOut;
  logic        extOn;
  logic [32:0] segmentOut;
  logic [32:0] lastPat;
  logic [32:0] prevSample;
  logic [32:0] shown;
  logic [32:0] pushed;
  logic [32:0] pat;
  logic [32:0] expQ[$];
  int          errCount;
  int          checks;
  int          extCnt;
  int          n;

  slcd_driver #(.OSC_CYCLES(OSC)) dut (
    .ref_clk          (ref_clk),
    .rst              (rst),
    .serClk           (serClk),
    .serData          (serData),
    .rcTimingPin      (rcTimingPin),
    .backplaneClockIn (backplaneClockIn),
    .segmentOut       (segmentOut),
    .backplaneDriveOut(backplaneDriveOut)
  );

  slcd_host_model ctl (
    .serClk (serClk),
    .serData(serData)
  );

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", checks, errCount);
    if (errCount == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp) begin
      errCount++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  // Notes the expected pattern if it differs from the last noted one, then sends the frame
  task automatic frame(input logic [32:0] p, input int pauseAt, input logic padVal);
    if (p !== pushed) begin
      expQ.push_back(p);
      pushed = p;
    end
    ctl.send_frame(p, pauseAt, padVal);
  endtask : frame

  // Cycles until the backplane output next changes
  task automatic bp_half(output int cnt);
    logic b;
    b   = backplaneDriveOut;
    cnt = 0;
    while (backplaneDriveOut === b && cnt < 300) begin
      @(posedge ref_clk);
      #1;
      cnt++;
    end
  endtask : bp_half

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // Pattern seen on the segments, compared with the oldest note
  always @(negedge ref_clk) begin
    if (!rst) begin
      shown = segmentOut ^ {33{backplaneDriveOut}};
      if (shown === prevSample && shown !== lastPat) begin
        if (expQ.size() == 0) check(shown, lastPat);
        else check(shown, expQ.pop_front());
        lastPat = shown;
      end
      prevSample = shown;
    end
  end

  // External backplane square wave, even duty
  always @(posedge ref_clk) begin
    #1;
    if (extOn) begin
      extCnt++;
      if (extCnt % 10 == 0) backplaneClockIn = ~backplaneClockIn;
    end
  end

  initial begin
    rst              = 1'b1;
    rcTimingPin      = 1'b1;
    backplaneClockIn = 1'b0;
    extOn            = 1'b0;
    extCnt           = 0;
    errCount         = 0;
    checks           = 0;
    pushed           = 33'h0_0000_0000;
    lastPat          = 33'h0_0000_0000;
    prevSample       = 33'h0_0000_0000;
    n                = $urandom(32'h79C1);
    repeat (20) @(posedge ref_clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge ref_clk);
    #1;
    check(segmentOut ^ {33{backplaneDriveOut}}, 33'h0_0000_0000);
    bp_half(n);
    bp_half(n);
    check(33'(n), 33'(8 * OSC));
    #13;
    ctl.idle_clocks(3);
    for (int i = 0; i < 8; i++) begin
      pat = 33'({$urandom(), $urandom()});
      frame(pat, -1, 1'b0);
      if (i[0]) #523;
    end
    frame(pushed, -1, 1'b0);
    frame(pushed, 20, 1'b0);
    for (int k = 0; k < 33; k++) frame(33'h0_0000_0001 << k, -1, 1'b0);
    frame(33'h1_FFFF_FFFF, -1, 1'b1);
    frame(33'({$urandom(), $urandom()}), 17, 1'b0);
    repeat (20) @(posedge ref_clk);
    check(33'(expQ.size()), 33'h0_0000_0000);
    #1 rcTimingPin = 1'b0;
    extOn = 1'b1;
    repeat (40) @(posedge ref_clk);
    #1;
    bp_half(n);
    bp_half(n);
    check(33'(n), 33'h0_0000_000A);
    repeat (30) @(posedge ref_clk);
    tally_and_finish();
  end

  initial begin
    repeat (40000) @(posedge ref_clk);
    errCount++;
    $display("ERROR t=%0t watchdog got=%h exp=%h", $time, 1'b0, 1'b1);
    tally_and_finish();
  end
endmodule : serial_lcd_segment_driver_bench
